// File: bench/tb_or_return_rotate_exec.sv
// self-checking bench for the or/return/rotate execution unit
// assumes the unit's internal data memory is preloaded through the ext ports
`timescale 1ns/10ps

module tb_or_return_rotate_exec;

	logic clk = 1'b0; // 40 MHz system clock
	logic reset = 1'b1; // synchronous, active high
	logic instValid = 1'b0;
	or_return_rotate_pkg::op_e instOp = or_return_rotate_pkg::OP_OR_IMM;
	logic [7:0] instAddr = 8'h00;
	logic [7:0] instImm = 8'h00;
	logic [11:0] stackTop = 12'h000;
	logic irqPending = 1'b0;
	logic extWrEn = 1'b0;
	logic [7:0] extAddr = 8'h00;
	logic [7:0] extData = 8'h00;
	logic busy, done, zeroFlag, masterIntEnable, pcLoad, stackPop, irqService;
	logic [7:0] workingReg;
	logic [11:0] pcValue;
	int fail_count = 0; // mismatches
	int num_checks = 0; // comparisons
	int cycles = 0; // timeout counter

	always #12.5 clk = ~clk;

	or_return_rotate_exec or_return_rotate_exec_i (.clk(clk), .reset(reset), .instValid(instValid),
		.instOp(instOp), .instAddr(instAddr), .instImm(instImm), .stackTop(stackTop),
		.irqPending(irqPending), .extWrEn(extWrEn), .extAddr(extAddr), .extData(extData),
		.busy(busy), .done(done), .workingReg(workingReg), .zeroFlag(zeroFlag),
		.masterIntEnable(masterIntEnable), .pcLoad(pcLoad), .pcValue(pcValue),
		.stackPop(stackPop), .irqService(irqService));

	////////////////////////////////////////////////////////////////////////
	// shared tasks

	// four-state compare, so an unknown never matches
	task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string msg);
		num_checks++;
		if (got !== exp) begin
			fail_count++;
			$display("CHECK FAILED t=%0t %s got %h exp %h", $time, msg, got, exp);
		end
	endtask : chk

	// preload one byte while idle with no instruction offered
	task automatic poke(input logic [7:0] a, input logic [7:0] d);
		@(negedge clk);
		extWrEn = 1'b1;
		extAddr = a;
		extData = d;
		@(negedge clk);
		extWrEn = 1'b0;
	endtask : poke

	// offer one instruction, return in the cycle done is high
	task automatic issue(input or_return_rotate_pkg::op_e op, input logic [7:0] a, input logic [7:0] imm,
		input logic [11:0] top, input logic irq);
		int n;
		n = 0;
		@(negedge clk);
		instValid = 1'b1;
		instOp = op;
		instAddr = a;
		instImm = imm;
		stackTop = top;
		irqPending = irq;
		@(negedge clk);
		instValid = 1'b0;
		// memory forms hold busy for the cycle after acceptance
		chk(busy, (op == or_return_rotate_pkg::OP_OR_MEM || op == or_return_rotate_pkg::OP_OR_TO_MEM
			|| op == or_return_rotate_pkg::OP_ROTATE_LEFT), "busy level");
		// bounded wait: memory forms answer one cycle later
		while (done !== 1'b1 && n < 3) begin
			@(negedge clk);
			n++;
		end
		chk(done, 1'b1, "done missing");
	endtask : issue

	////////////////////////////////////////////////////////////////////////
	// scenarios

	// immediate or, zero flag both ways, reset values first
	task automatic t_or_imm;
		chk({workingReg, zeroFlag, masterIntEnable}, 12'h000, "reset state");
		issue(or_return_rotate_pkg::OP_OR_IMM, 8'h00, 8'h00, 12'h000, 1'b0);
		chk({workingReg, zeroFlag}, 12'h001, "or imm zero");
		issue(or_return_rotate_pkg::OP_OR_IMM, 8'h00, 8'hA5, 12'h000, 1'b0);
		chk({workingReg, zeroFlag}, 12'h14A, "or imm a5");
		issue(or_return_rotate_pkg::OP_OR_IMM, 8'h00, 8'h5A, 12'h000, 1'b0);
		chk(workingReg, 8'hFF, "or imm merge");
		$display("t_or_imm done");
	endtask : t_or_imm

	// memory or into the working register
	task automatic t_or_mem;
		poke(8'h10, 8'h3C);
		poke(8'h11, 8'h00);
		issue(or_return_rotate_pkg::OP_SUB_EXIT_LIT, 8'h00, 8'h00, 12'hABC, 1'b0);
		chk({pcLoad, stackPop, pcValue}, 14'h3ABC, "exit lit pc");
		chk(workingReg, 8'h00, "exit lit value");
		issue(or_return_rotate_pkg::OP_OR_MEM, 8'h11, 8'h00, 12'h000, 1'b0);
		chk({workingReg, zeroFlag}, 12'h001, "or mem zero");
		issue(or_return_rotate_pkg::OP_OR_MEM, 8'h10, 8'h00, 12'h000, 1'b0);
		chk({workingReg, zeroFlag}, 12'h078, "or mem 3c");
		$display("t_or_mem done");
	endtask : t_or_mem

	// or written back to memory, read back through a cleared register
	task automatic t_or_to_mem;
		poke(8'h20, 8'hF0);
		issue(or_return_rotate_pkg::OP_SUB_EXIT_LIT, 8'h00, 8'h0F, 12'h001, 1'b0);
		issue(or_return_rotate_pkg::OP_OR_TO_MEM, 8'h20, 8'h00, 12'h000, 1'b0);
		chk({workingReg, zeroFlag}, 12'h01E, "or to mem keeps reg");
		issue(or_return_rotate_pkg::OP_SUB_EXIT_LIT, 8'h00, 8'h00, 12'h002, 1'b0);
		issue(or_return_rotate_pkg::OP_OR_MEM, 8'h20, 8'h00, 12'h000, 1'b0);
		chk(workingReg, 8'hFF, "or to mem stored");
		$display("t_or_to_mem done");
	endtask : t_or_to_mem

	// rotate wraps bit 7 into bit 0, flags left alone
	task automatic t_rotate;
		poke(8'h30, 8'h81);
		issue(or_return_rotate_pkg::OP_SUB_EXIT_LIT, 8'h00, 8'h00, 12'h003, 1'b0);
		issue(or_return_rotate_pkg::OP_OR_IMM, 8'h00, 8'h00, 12'h000, 1'b0);
		issue(or_return_rotate_pkg::OP_ROTATE_LEFT, 8'h30, 8'h00, 12'h000, 1'b0);
		chk({workingReg, zeroFlag}, 12'h001, "rotate touches reg or flag");
		issue(or_return_rotate_pkg::OP_OR_MEM, 8'h30, 8'h00, 12'h000, 1'b0);
		chk(workingReg, 8'h03, "rotate result");
		$display("t_rotate done");
	endtask : t_rotate

	// plain exit, then handler exit without and with a pending request
	task automatic t_returns;
		// register still holds 03 from the rotate scenario, so the or gives 43
		issue(or_return_rotate_pkg::OP_OR_IMM, 8'h00, 8'h40, 12'h000, 1'b0);
		issue(or_return_rotate_pkg::OP_SUB_EXIT, 8'h00, 8'h11, 12'h123, 1'b0);
		chk({pcLoad, stackPop, pcValue}, 14'h3123, "exit pc");
		chk({workingReg, zeroFlag, masterIntEnable, irqService}, 12'h218, "exit side effects");
		issue(or_return_rotate_pkg::OP_HANDLER_EXIT, 8'h00, 8'h00, 12'h456, 1'b0);
		chk({pcLoad, pcValue, masterIntEnable}, 14'h28AD, "handler exit");
		chk({irqService, workingReg, zeroFlag}, 12'h086, "handler exit no irq");
		issue(or_return_rotate_pkg::OP_HANDLER_EXIT, 8'h00, 8'h00, 12'h789, 1'b1);
		chk({pcLoad, irqService, pcValue}, 14'h3789, "pending serviced");
		$display("t_returns done");
	endtask : t_returns

	////////////////////////////////////////////////////////////////////////
	// verdict and run control

	task automatic results;
		$display("checks %0d mismatches %0d", num_checks, fail_count);
		if (fail_count == 0 && num_checks > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask : results

	// hang guard, far above the few dozen cycles the tests need
	always @(posedge clk) begin
		cycles++;
		if (cycles >= 2000) begin
			fail_count++;
			$display("CHECK FAILED t=%0t timeout", $time);
			results();
		end
	end

	// main sequence: two reset edges, then the scenarios
	initial begin
		repeat (2) @(posedge clk);
		@(negedge clk);
		reset = 1'b0;
		t_or_imm();
		t_or_mem();
		t_or_to_mem();
		t_rotate();
		t_returns();
		results();
	end

endmodule : tb_or_return_rotate_exec

// File: verilog/data_mem_store.sv
// small data memory: synchronous write, registered read
// assumes the controller holds addr steady for the read-modify-write
`timescale 1ns/10ps

module data_mem_store #(
	parameter int ADDR_W = 8,
	parameter int DATA_W = 8,
	parameter int DEPTH = 256
) (
	input wire logic clk,
	input wire logic reset,
	mem_if.store bus
);

	logic [DATA_W-1:0] cells [DEPTH]; // storage array, not reset

	////////////////////////////////////////////////////////////////////////
	// read returns the old word on a same-address write
	always_ff @(posedge clk) begin
		if (bus.wrEn) begin
			cells[bus.addr] <= bus.wrData;
		end
		if (reset) begin
			bus.rdData <= '0;
		end else begin
			bus.rdData <= cells[bus.addr];
		end
	end

endmodule : data_mem_store

// File: verilog/mem_if.sv
// bundle between the execution unit and its data memory store
// assumes one clock; read data appear one edge after the address
`timescale 1ns/10ps

interface mem_if #(
	parameter int ADDR_W = 8,
	parameter int DATA_W = 8
);
	logic [ADDR_W-1:0] addr; // byte address
	logic wrEn; // write strobe
	logic [DATA_W-1:0] wrData; // write data
	logic [DATA_W-1:0] rdData; // registered read data

	modport ctrl (output addr, output wrEn, output wrData, input rdData);
	modport store (input addr, input wrEn, input wrData, output rdData);
endinterface : mem_if

// File: verilog/or_return_rotate_exec.sv
// execution unit for the OR, return and rotate-left instructions
// assumes decode presents one instruction at a time with stack top and
// interrupt pending status already valid in the same cycle
`timescale 1ns/10ps
`include "or_return_rotate_regs.svh"

module or_return_rotate_exec #(
	parameter int ADDR_W = 8,
	parameter int PC_W = 12,
	parameter int DEPTH = 256
) (
	input wire logic clk,
	input wire logic reset,
	input wire logic instValid,
	input wire or_return_rotate_pkg::op_e instOp,
	input wire logic [ADDR_W-1:0] instAddr,
	input wire logic [7:0] instImm,
	input wire logic [PC_W-1:0] stackTop,
	input wire logic irqPending,
	input wire logic extWrEn,
	input wire logic [ADDR_W-1:0] extAddr,
	input wire logic [7:0] extData,
	output logic busy,
	output logic done,
	output logic [7:0] workingReg,
	output logic zeroFlag,
	output logic masterIntEnable,
	output logic pcLoad,
	output logic [PC_W-1:0] pcValue,
	output logic stackPop,
	output logic irqService
);

	// whole state of the unit
	typedef struct packed {
		or_return_rotate_pkg::state_e state;
		or_return_rotate_pkg::op_e op; // latched memory op
		logic [ADDR_W-1:0] addr; // latched address
		logic busy;
		logic done;
		logic [7:0] workingReg;
		logic zeroFlag;
		logic masterIntEnable;
		logic pcLoad;
		logic [PC_W-1:0] pcValue;
		logic stackPop;
		logic irqService;
	} exec_s;

	exec_s st_ff; // registered state
	exec_s nxt_st; // next state
	logic accept; // instruction taken this cycle
	logic [7:0] orRes; // OR of register and memory
	logic [7:0] rotRes; // rotated memory byte

	mem_if #(.ADDR_W(ADDR_W), .DATA_W(8)) memBus();

	data_mem_store #(.ADDR_W(ADDR_W), .DATA_W(8), .DEPTH(DEPTH)) uStore (
		.clk(clk),
		.reset(reset),
		.bus(memBus.store)
	);

	////////////////////////////////////////////////////////////////////////
	// datapath terms
	assign accept = instValid && (st_ff.state == or_return_rotate_pkg::ST_IDLE);
	assign orRes = st_ff.workingReg | memBus.rdData;
	assign rotRes = {memBus.rdData[`ORR_MSB_POS-1:`ORR_LSB_POS], memBus.rdData[`ORR_MSB_POS]};

	////////////////////////////////////////////////////////////////////////
	// memory port steering; the address is held across the read-modify-write
	always_comb begin
		memBus.addr = extAddr;
		memBus.wrEn = 1'b0;
		memBus.wrData = extData;
		if (st_ff.state == or_return_rotate_pkg::ST_MEM) begin
			memBus.addr = st_ff.addr;
			if (st_ff.op == or_return_rotate_pkg::OP_OR_TO_MEM) begin
				memBus.wrEn = 1'b1;
				memBus.wrData = orRes;
			end else if (st_ff.op == or_return_rotate_pkg::OP_ROTATE_LEFT) begin
				memBus.wrEn = 1'b1;
				memBus.wrData = rotRes;
			end
		end else if (instValid) begin
			memBus.addr = instAddr; // start the read
		end else begin
			memBus.wrEn = extWrEn; // preload only when no instruction is offered
		end
	end

	////////////////////////////////////////////////////////////////////////
	// next-state logic
	always_comb begin
		nxt_st = st_ff;
		nxt_st.done = 1'b0; // pulses
		nxt_st.pcLoad = 1'b0;
		nxt_st.stackPop = 1'b0;
		nxt_st.irqService = 1'b0;
		case (st_ff.state)
			or_return_rotate_pkg::ST_IDLE: begin
				if (accept) begin
					case (instOp)
						or_return_rotate_pkg::OP_OR_IMM: begin
							nxt_st.workingReg = st_ff.workingReg | instImm;
							nxt_st.zeroFlag = ((st_ff.workingReg | instImm) == 8'h00);
							nxt_st.done = 1'b1;
						end
						or_return_rotate_pkg::OP_SUB_EXIT,
						or_return_rotate_pkg::OP_SUB_EXIT_LIT,
						or_return_rotate_pkg::OP_HANDLER_EXIT: begin
							// zero flag untouched on every return form; the handler exit sets masterIntEnable
							nxt_st.pcLoad = 1'b1;
							nxt_st.stackPop = 1'b1;
							nxt_st.pcValue = stackTop;
							nxt_st.done = 1'b1;
							if (instOp == or_return_rotate_pkg::OP_SUB_EXIT_LIT) begin
								nxt_st.workingReg = instImm;
							end
							if (instOp == or_return_rotate_pkg::OP_HANDLER_EXIT) begin
								nxt_st.masterIntEnable = `ORR_MIE_SET;
								nxt_st.irqService = irqPending;
							end
						end
						default: begin
							// memory forms wait one edge for read data
							nxt_st.state = or_return_rotate_pkg::ST_MEM;
							nxt_st.op = instOp;
							nxt_st.addr = instAddr;
							nxt_st.busy = 1'b1;
						end
					endcase
				end
			end
			or_return_rotate_pkg::ST_MEM: begin
				nxt_st.state = or_return_rotate_pkg::ST_IDLE;
				nxt_st.busy = 1'b0;
				nxt_st.done = 1'b1;
				case (st_ff.op)
					or_return_rotate_pkg::OP_OR_MEM: begin
						nxt_st.workingReg = orRes;
						nxt_st.zeroFlag = (orRes == 8'h00);
					end
					or_return_rotate_pkg::OP_OR_TO_MEM: begin
						nxt_st.zeroFlag = (orRes == 8'h00);
					end
					default: begin
						// rotate: memory only, no flag touched
					end
				endcase
			end
			default: begin
				nxt_st.state = or_return_rotate_pkg::ST_IDLE;
			end
		endcase
	end

	////////////////////////////////////////////////////////////////////////
	// state register
	always_ff @(posedge clk) begin
		if (reset) begin
			st_ff <= '0;
			st_ff.state <= or_return_rotate_pkg::ST_IDLE;
			st_ff.workingReg <= `ORR_WREG_RST;
			st_ff.zeroFlag <= `ORR_ZERO_RST;
			st_ff.masterIntEnable <= `ORR_MIE_RST;
		end else begin
			st_ff <= nxt_st;
		end
	end

	// outputs straight from the state register
	assign busy = st_ff.busy;
	assign done = st_ff.done;
	assign workingReg = st_ff.workingReg;
	assign zeroFlag = st_ff.zeroFlag;
	assign masterIntEnable = st_ff.masterIntEnable;
	assign pcLoad = st_ff.pcLoad;
	assign pcValue = st_ff.pcValue;
	assign stackPop = st_ff.stackPop;
	assign irqService = st_ff.irqService;

	////////////////////////////////////////////////////////////////////////
	// checks
	default clocking cb @(posedge clk); endclocking
	default disable iff (reset);

	sequence s_take(or_return_rotate_pkg::op_e o);
		accept && instOp == o;
	endsequence
	sequence s_modify(or_return_rotate_pkg::op_e o);
		st_ff.state == or_return_rotate_pkg::ST_MEM && st_ff.op == o;
	endsequence

	// the read-only form must not write during its memory cycle
	property p_or_mem;
		s_modify(or_return_rotate_pkg::OP_OR_MEM) |-> !memBus.wrEn ##1 workingReg == $past(orRes) && done;
	endproperty
	a_or_mem: assert property (p_or_mem) else $error("or memory result wrong");

	property p_or_imm;
		s_take(or_return_rotate_pkg::OP_OR_IMM) |=> workingReg == ($past(workingReg) | $past(instImm))
			&& masterIntEnable == $past(masterIntEnable) && !pcLoad;
	endproperty
	a_or_imm: assert property (p_or_imm) else $error("or immediate result wrong");

	property p_or_to_mem;
		s_take(or_return_rotate_pkg::OP_OR_TO_MEM) ##1 s_modify(or_return_rotate_pkg::OP_OR_TO_MEM)
			|-> memBus.wrEn && memBus.wrData == (workingReg | memBus.rdData) ##1 workingReg == $past(workingReg, 2);
	endproperty
	a_or_to_mem: assert property (p_or_to_mem) else $error("or to memory wrong");

	property p_sub_exit;
		s_take(or_return_rotate_pkg::OP_SUB_EXIT) |=> pcLoad && stackPop && pcValue == $past(stackTop)
			&& zeroFlag == $past(zeroFlag) && workingReg == $past(workingReg);
	endproperty
	a_sub_exit: assert property (p_sub_exit) else $error("subroutine exit wrong");

	property p_sub_exit_lit;
		s_take(or_return_rotate_pkg::OP_SUB_EXIT_LIT) |=> pcLoad && workingReg == $past(instImm)
			&& zeroFlag == $past(zeroFlag);
	endproperty
	a_sub_exit_lit: assert property (p_sub_exit_lit) else $error("exit with literal wrong");

	property p_handler_exit;
		s_take(or_return_rotate_pkg::OP_HANDLER_EXIT) |=> pcLoad && masterIntEnable && zeroFlag == $past(zeroFlag);
	endproperty
	a_handler_exit: assert property (p_handler_exit) else $error("handler exit wrong");

	property p_pending_irq;
		s_take(or_return_rotate_pkg::OP_HANDLER_EXIT) |=> irqService == $past(irqPending);
	endproperty
	a_pending_irq: assert property (p_pending_irq) else $error("pending interrupt not serviced");

	property p_rotate;
		s_modify(or_return_rotate_pkg::OP_ROTATE_LEFT) |-> memBus.wrEn
			&& memBus.wrData == {memBus.rdData[6:0], memBus.rdData[7]} ##1 $stable(zeroFlag) && $stable(workingReg);
	endproperty
	a_rotate: assert property (p_rotate) else $error("rotate left wrong");

	property p_zero;
		s_modify(or_return_rotate_pkg::OP_OR_TO_MEM) |=> zeroFlag == ($past(orRes) == 8'h00);
	endproperty
	a_zero: assert property (p_zero) else $error("zero flag wrong");

endmodule : or_return_rotate_exec

// File: verilog/or_return_rotate_pkg.sv
// types shared by the or/return/rotate execution unit
// assumes the decode path has already classified the opcode
package or_return_rotate_pkg;

	// instruction classes handled by this slice
	typedef enum logic [2:0] {
		OP_OR_MEM,
		OP_OR_IMM,
		OP_OR_TO_MEM,
		OP_SUB_EXIT,
		OP_SUB_EXIT_LIT,
		OP_HANDLER_EXIT,
		OP_ROTATE_LEFT
	} op_e;

	// sequencer states
	typedef enum logic [0:0] {
		ST_IDLE,
		ST_MEM
	} state_e;

endpackage : or_return_rotate_pkg

// File: verilog/or_return_rotate_regs.svh
// reset values, field positions and timing counts for the or/return/rotate slice
// assumes an 8-bit data path; included by the execution unit only
`ifndef OR_RETURN_ROTATE_REGS_SVH
`define OR_RETURN_ROTATE_REGS_SVH

// reset values of the architectural state held here
`define ORR_WREG_RST 8'h00
`define ORR_ZERO_RST 1'b0
`define ORR_MIE_RST 1'b0
// bit positions of the rotate
`define ORR_MSB_POS 7
`define ORR_LSB_POS 0
// master interrupt enable value written by the handler exit
`define ORR_MIE_SET 1'b1
// cycles from acceptance to done
`define ORR_REG_CYCLES 1
`define ORR_MEM_CYCLES 2

`endif
